// >>> core/cycle_seq_defs.svh
// Timing counts and strobe patterns for the machine-cycle sequencer
`ifndef CYCLE_SEQ_DEFS_SVH
`define CYCLE_SEQ_DEFS_SVH
`define T_STATES_PER_BUS 3
`define IDLE_CMP_REPEAT 5
`define IDLE_CMP_DONE 3
`define IDLE_CMP_SINGLE 3
`define IDLE_BRANCH_TAKEN 2
`define IDLE_ONE 1
`define STROBE_IDLE 7'h7F
`define STROBE_FETCH1 7'h2A
`define STROBE_FETCH2 7'h6A
`define STROBE_MEM_RD 7'h7A
`define STROBE_MEM_WR 7'h79
`define STROBE_HALT 7'h0A
`endif

// >>> core/cycle_seq_pkg.sv
// Types for the machine-cycle sequencer
package cycle_seq_pkg;
  typedef enum logic [3:0] {
    instr_single = 4'h0,
    instr_single_idle = 4'h1,
    instr_prefixed = 4'h2,
    instr_compare = 4'h3,
    instr_compare_repeat = 4'h4,
    instr_branch = 4'h5,
    instr_ex_stack = 4'h6,
    instr_ex_stack_idx = 4'h7,
    instr_halt = 4'h8,
    instr_inc_mem = 4'h9,
    instr_enable_int = 4'hA
  } instr_class_e;
  typedef enum logic [2:0] {
    addr_opcode = 3'h0,
    addr_operand = 3'h1,
    addr_pointer = 3'h2,
    addr_stack = 3'h3,
    addr_stack_plus1 = 3'h4,
    addr_none = 3'h5
  } addr_src_e;
  typedef enum logic [2:0] {
    data_float = 3'h0,
    data_opcode = 3'h1,
    data_read = 3'h2,
    data_write_hi = 3'h3,
    data_write_lo = 3'h4
  } data_src_e;
  typedef struct packed {
    logic is_bus;
    logic [6:0] strobes;
    addr_src_e addr;
    data_src_e data;
    logic [2:0] idle_len;
    logic last;
  } mcycle_s;
endpackage

// >>> core/bus_cycle_if.sv
// Carrier between the sequencer and its step table
`timescale 1ns/1ps
`default_nettype none
interface bus_cycle_if;
  import cycle_seq_pkg::*;
  instr_class_e instr;
  logic [3:0] step;
  logic repeat_go;
  logic branch_go;
  mcycle_s cyc;
  modport seq (output instr, output step, output repeat_go, output branch_go, input cyc);
  modport table_side (input instr, input step, input repeat_go, input branch_go, output cyc);
endinterface
`default_nettype wire

// >>> core/cycle_step_table.sv
// Machine-cycle table: step index to bus cycle description
`timescale 1ns/1ps
`default_nettype none
`include "cycle_seq_defs.svh"
module cycle_step_table (
  bus_cycle_if.table_side tbl
);
  import cycle_seq_pkg::*;

  function automatic mcycle_s bus(input logic [6:0] s, input addr_src_e a, input data_src_e d, input logic l);
    bus = '{1'b1, s, a, d, 3'h0, l};
  endfunction

  function automatic mcycle_s idle(input logic [2:0] n, input logic l);
    idle = '{1'b0, `STROBE_IDLE, addr_none, data_float, n, l};
  endfunction

  always_comb begin
    tbl.cyc = bus(`STROBE_FETCH1, addr_opcode, data_opcode, 1'b1);
    unique case (tbl.instr)
      instr_single, instr_enable_int: begin
        tbl.cyc = bus(`STROBE_FETCH1, addr_opcode, data_opcode, 1'b1);
      end
      instr_single_idle: begin
        if (tbl.step != 4'h0) tbl.cyc = idle(3'(`IDLE_ONE), 1'b1);
        else tbl.cyc = bus(`STROBE_FETCH1, addr_opcode, data_opcode, 1'b0);
      end
      instr_prefixed: begin
        if (tbl.step != 4'h0) tbl.cyc = bus(`STROBE_FETCH2, addr_opcode, data_opcode, 1'b1);
        else tbl.cyc = bus(`STROBE_FETCH1, addr_opcode, data_opcode, 1'b0);
      end
      instr_compare, instr_compare_repeat: begin
        unique case (tbl.step)
          4'h0: tbl.cyc = bus(`STROBE_FETCH1, addr_opcode, data_opcode, 1'b0);
          4'h1: tbl.cyc = bus(`STROBE_FETCH2, addr_opcode, data_opcode, 1'b0);
          4'h2: tbl.cyc = bus(`STROBE_MEM_RD, addr_pointer, data_read, 1'b0);
          default: begin
            if (tbl.instr == instr_compare_repeat && tbl.repeat_go)
              tbl.cyc = idle(3'(`IDLE_CMP_REPEAT), 1'b1);
            else if (tbl.instr == instr_compare_repeat)
              tbl.cyc = idle(3'(`IDLE_CMP_DONE), 1'b1);
            else
              tbl.cyc = idle(3'(`IDLE_CMP_SINGLE), 1'b1);
          end
        endcase
      end
      instr_branch: begin
        unique case (tbl.step)
          4'h0: tbl.cyc = bus(`STROBE_FETCH1, addr_opcode, data_opcode, 1'b0);
          4'h1: tbl.cyc = idle(3'(`IDLE_ONE), 1'b0);
          4'h2: tbl.cyc = bus(`STROBE_MEM_RD, addr_operand, data_read, !tbl.branch_go);
          default: tbl.cyc = idle(3'(`IDLE_BRANCH_TAKEN), 1'b1);
        endcase
      end
      instr_ex_stack, instr_ex_stack_idx: begin
        unique case (tbl.step - ((tbl.instr == instr_ex_stack_idx) ? 4'h1 : 4'h0))
          4'h1: tbl.cyc = bus(`STROBE_MEM_RD, addr_stack, data_read, 1'b0);
          4'h2: tbl.cyc = bus(`STROBE_MEM_RD, addr_stack_plus1, data_read, 1'b0);
          4'h3: tbl.cyc = idle(3'(`IDLE_ONE), 1'b0);
          4'h4: tbl.cyc = bus(`STROBE_MEM_WR, addr_stack_plus1, data_write_hi, 1'b0);
          4'h5: tbl.cyc = bus(`STROBE_MEM_WR, addr_stack, data_write_lo, 1'b1);
          default: begin
            if (tbl.step == 4'h0) tbl.cyc = bus(`STROBE_FETCH1, addr_opcode, data_opcode, 1'b0);
            else tbl.cyc = bus(`STROBE_FETCH2, addr_opcode, data_opcode, 1'b0);
          end
        endcase
      end
      instr_halt: begin
        if (tbl.step != 4'h0) tbl.cyc = bus(`STROBE_HALT, addr_opcode, data_opcode, 1'b1);
        else tbl.cyc = bus(`STROBE_FETCH1, addr_opcode, data_opcode, 1'b0);
      end
      instr_inc_mem: begin
        unique case (tbl.step)
          4'h0: tbl.cyc = bus(`STROBE_FETCH1, addr_opcode, data_opcode, 1'b0);
          4'h1: tbl.cyc = bus(`STROBE_MEM_RD, addr_pointer, data_read, 1'b0);
          4'h2: tbl.cyc = idle(3'(`IDLE_ONE), 1'b0);
          default: tbl.cyc = bus(`STROBE_MEM_WR, addr_pointer, data_write_lo, 1'b1);
        endcase
      end
      default: tbl.cyc = bus(`STROBE_FETCH1, addr_opcode, data_opcode, 1'b1);
    endcase
  end
endmodule
`default_nettype wire

// >>> core/machine_cycle_bus_sequencer.sv
// Machine-cycle bus sequencer top
// How it works
// - Opcode fetch: three states, fetch strobes low
// - Repeat compare continuing: five idle states after read
// - Repeat compare ending: three idle states only
// - Branch taken: idle, read offset, two idles
// - Branch: ignore DMA/refresh/release from the first idle on
// - Interrupt-enable fetch end: interrupts not sampled
`timescale 1ns/1ps
`default_nettype none
`include "cycle_seq_defs.svh"
module machine_cycle_bus_sequencer (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic start_i,
  input wire cycle_seq_pkg::instr_class_e instr_i,
  input wire logic counter_nonzero_i,
  input wire logic match_found_i,
  input wire logic halt_release_i,
  input wire logic bus_request_i,
  input wire logic int_request_i,
  input wire logic [7:0] read_data_i,
  output logic busy_o,
  output logic done_o,
  output cycle_seq_pkg::addr_src_e addr_src_o,
  output cycle_seq_pkg::data_src_e data_src_o,
  output logic data_oe_o,
  output logic [7:0] capture_data_o,
  output logic read_strobe_n_o,
  output logic write_strobe_n_o,
  output logic mem_request_n_o,
  output logic io_request_n_o,
  output logic fetch_cycle_n_o,
  output logic halt_line_n_o,
  output logic status_line_n_o,
  output logic bus_grant_o,
  output logic int_sample_o
);
  import cycle_seq_pkg::*;

  typedef enum logic [2:0] {
    st_idle = 3'b001,
    st_bus = 3'b010,
    st_inner = 3'b100
  } seq_state_e;

  bus_cycle_if link ();
  cycle_step_table u_table (.tbl(link.table_side));

  seq_state_e state;
  instr_class_e instr;
  logic [3:0] step;
  logic [1:0] tcount;
  logic [2:0] idle_left;
  logic repeat_go;
  logic branch_go;
  logic bus_locked;
  logic [2:0] rel_sync;
  logic rel_seen;
  logic [2:0] breq_sync;
  logic breq_seen;
  logic [2:0] irq_sync;
  logic irq_seen;
  logic cyc_end;

  assign link.instr = instr;
  assign link.step = step;
  assign link.repeat_go = repeat_go;
  assign link.branch_go = branch_go;

  ////////////////////////////////////////////////////////////////
  // Pin synchronisers, change counted when stages two and three agree
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      rel_sync <= 3'h0;
      breq_sync <= 3'h0;
      irq_sync <= 3'h0;
      rel_seen <= 1'b0;
      breq_seen <= 1'b0;
      irq_seen <= 1'b0;
    end else begin
      rel_sync <= {rel_sync[1:0], halt_release_i};
      breq_sync <= {breq_sync[1:0], bus_request_i};
      irq_sync <= {irq_sync[1:0], int_request_i};
      if (rel_sync[1] == rel_sync[2]) rel_seen <= rel_sync[2];
      if (breq_sync[1] == breq_sync[2]) breq_seen <= breq_sync[2];
      if (irq_sync[1] == irq_sync[2]) irq_seen <= irq_sync[2];
    end
  end

  ////////////////////////////////////////////////////////////////
  // Cycle sequencing
  always_comb begin
    cyc_end = 1'b0;
    if (state == st_bus && !link.cyc.is_bus)
      cyc_end = (link.cyc.idle_len == 3'h1);
    else if (state == st_bus)
      cyc_end = (tcount == 2'(`T_STATES_PER_BUS - 1)) && !(instr == instr_halt && step != 4'h0 && !rel_seen);
    else if (state == st_inner)
      cyc_end = (idle_left == 3'h1);
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      state <= st_idle;
      instr <= instr_single;
      step <= 4'h0;
      tcount <= 2'h0;
      idle_left <= 3'h0;
      repeat_go <= 1'b0;
      branch_go <= 1'b0;
    end else begin
      unique case (state)
        st_idle: begin
          if (start_i) begin
            instr <= instr_i;
            repeat_go <= counter_nonzero_i && !match_found_i;
            branch_go <= counter_nonzero_i;
            step <= 4'h0;
            tcount <= 2'h0;
            state <= st_bus;
          end
        end
        st_bus, st_inner: begin
          if (state == st_bus && !cyc_end) tcount <= tcount + 2'h1;
          if (state == st_inner && !cyc_end) idle_left <= idle_left - 3'h1;
          if (cyc_end) begin
            tcount <= 2'h0;
            if (link.cyc.last) begin
              state <= st_idle;
            end else begin
              step <= step + 4'h1;
              state <= st_bus;
            end
          end
          if (cyc_end && !link.cyc.last) begin
            if (instr == instr_halt) step <= 4'h1;
          end
        end
        default: state <= st_idle;
      endcase
      // First idle state is spent in st_bus, the rest counted here
      if (state == st_bus && link.cyc.is_bus == 1'b0 && !cyc_end) begin
        state <= st_inner;
        idle_left <= link.cyc.idle_len - 3'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // Bus strobes, address and data selection
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      {status_line_n_o, halt_line_n_o, fetch_cycle_n_o, io_request_n_o, mem_request_n_o,
       write_strobe_n_o, read_strobe_n_o} <= `STROBE_IDLE;
      addr_src_o <= addr_none;
      data_src_o <= data_float;
      data_oe_o <= 1'b0;
      capture_data_o <= 8'h00;
      busy_o <= 1'b0;
      done_o <= 1'b0;
    end else begin
      busy_o <= (state != st_idle);
      done_o <= busy_o && (state == st_idle);
      if (state == st_bus && link.cyc.is_bus) begin
        {status_line_n_o, halt_line_n_o, fetch_cycle_n_o, io_request_n_o, mem_request_n_o,
         write_strobe_n_o, read_strobe_n_o} <= link.cyc.strobes;
        addr_src_o <= link.cyc.addr;
        data_src_o <= link.cyc.data;
        data_oe_o <= (link.cyc.data == data_write_hi) || (link.cyc.data == data_write_lo);
      end else begin
        {status_line_n_o, halt_line_n_o, fetch_cycle_n_o, io_request_n_o, mem_request_n_o,
         write_strobe_n_o, read_strobe_n_o} <= `STROBE_IDLE;
        addr_src_o <= addr_none;
        data_src_o <= data_float;
        data_oe_o <= 1'b0;
      end
      if (state == st_bus && cyc_end && !read_strobe_n_o && !mem_request_n_o)
        capture_data_o <= read_data_i;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Bus release at a machine-cycle end except within a branch after its fetch, interrupt sampling at instruction end except for interrupt-enable
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      bus_locked <= 1'b0;
      bus_grant_o <= 1'b0;
      int_sample_o <= 1'b0;
    end else begin
      if (state == st_idle)
        bus_locked <= 1'b0;
      else if (instr == instr_branch && step != 4'h0)
        bus_locked <= 1'b1;
      bus_grant_o <= breq_seen && !bus_locked && (state == st_idle || cyc_end) &&
                     !(instr == instr_branch && state != st_idle && step != 4'h0);
      int_sample_o <= irq_seen && (state != st_idle) && cyc_end && link.cyc.last &&
                      (instr != instr_enable_int);
    end
  end
endmodule
`default_nettype wire

// >>> dv/bus_memory_model.sv
// Memory and I/O responder on the far side of the bus
`timescale 1ns/1ps
`default_nettype none
module bus_memory_model (
  input wire logic sys_clk_i,
  input wire logic read_strobe_n_i,
  input wire logic mem_request_n_i,
  input wire logic io_request_n_i,
  input wire cycle_seq_pkg::addr_src_e addr_src_i,
  output logic [7:0] read_data_o
);
  import cycle_seq_pkg::*;
  logic [7:0] last = 8'h00;
  logic [7:0] val;
  wire logic sel = !read_strobe_n_i && !(mem_request_n_i && io_request_n_i);
  always_comb begin
    case (addr_src_i)
      addr_opcode: val = 8'h3C;
      addr_operand: val = 8'h96;
      default: val = 8'hC5;
    endcase
  end
  always @(posedge sys_clk_i) if (sel) last <= val;
  // Released bus shows the inverse of the last byte
  assign read_data_o = sel ? val : ~last;
endmodule
`default_nettype wire

// >>> dv/machine_cycle_bus_sequencer_chk.sv
// Port checks for the machine-cycle bus sequencer
`timescale 1ns/1ps
`default_nettype none
module machine_cycle_bus_sequencer_chk (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic start_i,
  input wire cycle_seq_pkg::instr_class_e instr_i,
  input wire logic counter_nonzero_i,
  input wire logic match_found_i,
  input wire logic busy_o,
  input wire logic done_o,
  input wire logic data_oe_o,
  input wire logic read_strobe_n_o,
  input wire logic write_strobe_n_o,
  input wire logic mem_request_n_o,
  input wire logic io_request_n_o,
  input wire logic fetch_cycle_n_o,
  input wire logic halt_line_n_o,
  input wire logic status_line_n_o,
  input wire logic bus_grant_o,
  input wire logic int_sample_o
);
  import cycle_seq_pkg::*;
  instr_class_e cls;
  logic cont, nz;
  logic [1:0] nrise;
  wire logic taken = start_i && !busy_o;
  wire logic idle = read_strobe_n_o && write_strobe_n_o;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);
  ////////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      cls <= instr_single;
      cont <= 1'b0;
      nz <= 1'b0;
    end else if (taken) begin
      cls <= instr_i;
      cont <= counter_nonzero_i && !match_found_i;
      nz <= counter_nonzero_i;
    end
  end
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) nrise <= 2'h0;
    else if (taken) nrise <= 2'h0;
    else if ($rose(read_strobe_n_o) && nrise != 2'h3) nrise <= nrise + 2'h1;
  end
  ////////////////////////////////////////////////////////////////
  AST_FETCH_STROBES: assert property (!fetch_cycle_n_o && halt_line_n_o |->
    !read_strobe_n_o && write_strobe_n_o && !mem_request_n_o && io_request_n_o) else $error("fetch strobes wrong");
  AST_FETCH_THREE: assert property ($fell(fetch_cycle_n_o) |->
    (!fetch_cycle_n_o && !status_line_n_o)[*3]) else $error("first fetch too short");
  AST_IDLE_HIGH: assert property (idle |->
    mem_request_n_o && io_request_n_o && fetch_cycle_n_o && status_line_n_o && !data_oe_o) else $error("idle not high");
  AST_STROBE_PAIR: assert property (!idle |->
    read_strobe_n_o != write_strobe_n_o && mem_request_n_o != io_request_n_o) else $error("unpaired strobes");
  AST_REPEAT_IDLE: assert property ($rose(read_strobe_n_o) && cls == instr_compare_repeat && cont |->
    (idle && !done_o)[*5] ##1 done_o) else $error("repeat idle count wrong");
  AST_REPEAT_END: assert property ($rose(read_strobe_n_o) && cls == instr_compare_repeat && !cont |->
    (idle && !done_o)[*3] ##1 done_o) else $error("ending idle count wrong");
  AST_BRANCH_OFFSET: assert property ($rose(read_strobe_n_o) && cls == instr_branch && nrise == 2'h0 |->
    ##1 !read_strobe_n_o[*3]) else $error("offset read misplaced");
  AST_BRANCH_TAKEN: assert property ($rose(read_strobe_n_o) && cls == instr_branch && nz && nrise == 2'h1 |->
    (idle && !done_o)[*2] ##1 done_o) else $error("branch idle count wrong");
  AST_NO_GRANT: assert property (cls == instr_branch && nrise != 2'h0 && busy_o |->
    !$rose(bus_grant_o)) else $error("grant inside branch");
  AST_EI_NO_SAMPLE: assert property (cls == instr_enable_int |-> !int_sample_o) else $error("sample after enable");
  COV_REPEAT: cover property ($rose(read_strobe_n_o) && cls == instr_compare_repeat && cont);
  COV_BRANCH: cover property ($rose(read_strobe_n_o) && cls == instr_branch && nrise == 2'h1);
  COV_SAMPLE: cover property ($rose(int_sample_o));
endmodule
bind machine_cycle_bus_sequencer machine_cycle_bus_sequencer_chk u_chk (.sys_clk_i, .reset_i, .start_i, .instr_i,
  .counter_nonzero_i, .match_found_i, .busy_o, .done_o, .data_oe_o, .read_strobe_n_o, .write_strobe_n_o,
  .mem_request_n_o, .io_request_n_o, .fetch_cycle_n_o, .halt_line_n_o, .status_line_n_o, .bus_grant_o, .int_sample_o);
`default_nettype wire

// >>> dv/machine_cycle_bus_sequencer_tb.sv
// Self-checking bench for the machine-cycle bus sequencer
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, a) begin checked++; if ((a) !== (e)) begin n_fail++; $display("MISMATCH %s exp %h got %h", nm, e, a); end end
module machine_cycle_bus_sequencer_tb;
  import cycle_seq_pkg::*;
  logic sys_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic start_i = 1'b0;
  instr_class_e instr_i = instr_single;
  logic counter_nonzero_i = 1'b0;
  logic match_found_i = 1'b0;
  logic halt_release_i = 1'b0;
  logic bus_request_i = 1'b0;
  logic int_request_i = 1'b0;
  logic [7:0] read_data_i, capture_data_o;
  logic busy_o, done_o, data_oe_o, bus_grant_o, int_sample_o;
  logic read_strobe_n_o, write_strobe_n_o, mem_request_n_o, io_request_n_o;
  logic fetch_cycle_n_o, halt_line_n_o, status_line_n_o;
  addr_src_e addr_src_o;
  data_src_e data_src_o;
  int n_fail = 0;
  int checked = 0;
  int n_int = 0;
  wire logic [7:0] strb = {done_o, read_strobe_n_o, write_strobe_n_o, mem_request_n_o, io_request_n_o,
    fetch_cycle_n_o, halt_line_n_o, status_line_n_o};
  always #25 sys_clk_i = ~sys_clk_i;
  always @(posedge sys_clk_i) if (int_sample_o === 1'b1) n_int++;
  machine_cycle_bus_sequencer DUT (.sys_clk_i, .reset_i, .start_i, .instr_i, .counter_nonzero_i, .match_found_i,
    .halt_release_i, .bus_request_i, .int_request_i, .read_data_i, .busy_o, .done_o, .addr_src_o, .data_src_o,
    .data_oe_o, .capture_data_o, .read_strobe_n_o, .write_strobe_n_o, .mem_request_n_o, .io_request_n_o,
    .fetch_cycle_n_o, .halt_line_n_o, .status_line_n_o, .bus_grant_o, .int_sample_o);
  bus_memory_model mem_model (.sys_clk_i, .read_strobe_n_i(read_strobe_n_o), .mem_request_n_i(mem_request_n_o),
    .io_request_n_i(io_request_n_o), .addr_src_i(addr_src_o), .read_data_o(read_data_i));
  ////////////////////////////////////////////////////////////////
  // One instruction: F/S fetches, R read, W write, I idle
  task automatic run(input instr_class_e c, input logic nzv, input logic mt, input string p);
    logic [7:0] e;
    @(negedge sys_clk_i);
    instr_i = c;
    counter_nonzero_i = nzv;
    match_found_i = mt;
    start_i = 1'b1;
    @(negedge sys_clk_i);
    start_i = 1'b0;
    for (int i = 0; i < p.len(); i++) begin
      @(negedge sys_clk_i);
      case (p[i])
        "F": e = 8'h2A;
        "S": e = 8'h2B;
        "R": e = 8'h2F;
        "W": e = 8'h4F;
        default: e = 8'h7F;
      endcase
      `CHK("strobes", e, strb)
    end
    @(negedge sys_clk_i);
    `CHK("end", 8'hFF, strb)
    repeat (2) @(negedge sys_clk_i);
  endtask
  task automatic t_fetch_int();
    int_request_i = 1'b1;
    repeat (6) @(negedge sys_clk_i);
    n_int = 0;
    run(instr_single, 1'b0, 1'b0, "FFF");
    `CHK("int sampled", 1'b1, n_int != 0)
    n_int = 0;
    run(instr_enable_int, 1'b0, 1'b0, "FFF");
    `CHK("int sampled", 1'b0, n_int != 0)
    int_request_i = 1'b0;
    run(instr_prefixed, 1'b0, 1'b0, "FFFSSS");
    run(instr_single_idle, 1'b0, 1'b0, "FFFI");
  endtask
  task automatic t_compare();
    run(instr_compare_repeat, 1'b1, 1'b0, "FFFSSSRRRIIIII");
    `CHK("capture", 8'hC5, capture_data_o)
    run(instr_compare_repeat, 1'b0, 1'b0, "FFFSSSRRRIII");
    run(instr_compare_repeat, 1'b1, 1'b1, "FFFSSSRRRIII");
    run(instr_compare, 1'b1, 1'b0, "FFFSSSRRRIII");
    run(instr_inc_mem, 1'b0, 1'b0, "FFFRRRIWWW");
  endtask
  task automatic t_branch();
    run(instr_branch, 1'b0, 1'b0, "FFFIRRR");
    fork
      run(instr_branch, 1'b1, 1'b0, "FFFIRRRII");
      begin
        repeat (4) @(negedge sys_clk_i);
        bus_request_i = 1'b1;
        repeat (4) begin
          @(negedge sys_clk_i);
          `CHK("grant", 1'b0, bus_grant_o)
        end
      end
    join
    bus_request_i = 1'b0;
    `CHK("capture", 8'h96, capture_data_o)
    repeat (8) @(negedge sys_clk_i);
  endtask
  task automatic final_report();
    if (n_fail == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(negedge sys_clk_i);
    reset_i = 1'b0;
    `CHK("idle", 8'h7F, strb)
    t_fetch_int();
    t_compare();
    t_branch();
    final_report();
  end
  initial begin
    repeat (3000) @(posedge sys_clk_i);
    n_fail++;
    final_report();
  end
endmodule
`default_nettype wire
